// File: rtl/esac_top.sv
// Purpose: APB configuration register and alignment control for external frame sync
// Assumes: pclk 125 MHz; reference enables come from the clock tree on this clock
// Notes: Answers every APB access in its access cycle with no wait states
`timescale 1ns/1ps
module esac_top
    import esac_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference sampling enables, half-UI steps
    input wire logic ref_coarse_en,
    input wire logic ref_fine_en,
    // External sync pin
    input wire logic ext_frame_sync_input,
    // Alignment outputs
    output logic align_low_rate_strobe,
    output logic align_line_rate_strobe,
    output logic align_frame_pulse_strobe,
    output esac_ctrl_t ctrl
);
    esac_cfg_t cfg;
    logic sync_meta, sync_sync;
    logic align_pulse;

    // APB decode
    wire logic hit = (paddr == ESAC_CFG_ADDR);
    wire logic wr_en = psel & penable & pwrite & hit;
    wire logic rd_acc = psel & ~penable & ~pwrite;
    wire logic [7:0] cfg_byte = {cfg.frame_pulse_independence, cfg.line_rate_sync_select,
        4'h0, cfg.sync_sample_phase}; // see (RULE_08)
    wire logic [31:0] next_prdata = hit ? {24'h000000, cfg_byte} : ESAC_UNMAPPED_DATA;
    wire logic [7:0] wmasked = pwdata[7:0] & ESAC_CFG_WMASK; // see (RULE_08)

    // Sampling rate and offset selection
    wire logic fine = cfg.line_rate_sync_select; // see (RULE_04)
    wire logic ref_en = fine ? ref_fine_en : ref_coarse_en; // see (RULE_02)
    // Tap 2 is on target; early uses one less, late adds half or one UI
    wire logic [2:0] next_delay = (cfg.sync_sample_phase == ESAC_PH_EARLY_HALF) ? 3'h1 :
        (cfg.sync_sample_phase == ESAC_PH_LATE_ONE) ? 3'h4 :
        (cfg.sync_sample_phase == ESAC_PH_LATE_HALF) ? 3'h3 : 3'h2; // see (RULE_06)

    // Register write; unused bits discarded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= esac_cfg_t'({ESAC_CFG_RESET[7:6], ESAC_CFG_RESET[1:0]});
        end else if (wr_en) begin
            cfg <= esac_cfg_t'({wmasked[ESAC_INDEP_BIT], wmasked[ESAC_LINE_BIT],
                wmasked[ESAC_PHASE_LSB+1:ESAC_PHASE_LSB]});
        end
    end

    // Read data latched in setup so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_acc) begin
                prdata <= next_prdata;
            end
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit; // Unmapped address flagged
        end
    end

    // Two-flop synchroniser on the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= 1'b1;
            sync_sync <= 1'b1;
        end else begin
            sync_meta <= ext_frame_sync_input;
            sync_sync <= sync_meta;
        end
    end

    esac_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .ref_en(ref_en),
        .sample_delay(ctrl.sample_delay),
        .sync_level(sync_sync),
        .align_pulse(align_pulse)
    );

    // Alignment strobes and steering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            align_low_rate_strobe <= 1'b0;
            align_line_rate_strobe <= 1'b0;
            align_frame_pulse_strobe <= 1'b0;
            ctrl <= '0;
        end else begin
            align_low_rate_strobe <= align_pulse; // see (RULE_01)
            align_line_rate_strobe <= align_pulse & fine; // see (RULE_01) see (RULE_03)
            // Independent pulses skip realignment so they never jump
            align_frame_pulse_strobe <= align_pulse & ~cfg.frame_pulse_independence; // see (RULE_07)
            ctrl.align_low_rate <= 1'b1;
            ctrl.align_line_rate <= fine; // see (RULE_03)
            ctrl.align_frame_pulses <= ~cfg.frame_pulse_independence; // see (RULE_07)
            ctrl.fine_sampling <= fine;
            ctrl.sample_delay <= next_delay;
        end
    end
endmodule // esac_top

// File: rtl/esac_pkg.sv
// Purpose: Constants and types for the external frame sync alignment block
// Assumes: APB slave, 32-bit data, one register word
// Notes: Summary of operation
// Summary of operation
// (RULE_01) Line-rate select clear: line-rate clocks ignore sync, only low-rate outputs align; code also aligns frame pulses while independence is clear.
// (RULE_02) Line-rate select clear: sync sampled at 6.48 MHz; system supplies 6.48 MHz.
// (RULE_03) Line-rate select set: OC-3 derived clocks and frame pulses align to sync.
// (RULE_04) Line-rate select set: sync sampled finely with 19.44 or 38.88 MHz reference.
// (RULE_05) Sync falling edge meeting reference falling edge is the zero offset point.
// (RULE_06) Phase field: 00 on target, 01 half UI early, 10 one UI late, 11 half late.
// (RULE_07) Independence clear keeps frame pulses aligned; set lets them run independently.
// (RULE_08) Bits five to two ignore writes and read as zero.
package esac_pkg;
    // Register index 0x7B is not a multiple of four, so byte address is index times four
    localparam logic [7:0] ESAC_CFG_INDEX = 8'h7B;
    localparam logic [11:0] ESAC_CFG_ADDR = {2'h0, ESAC_CFG_INDEX, 2'h0};
    localparam logic [7:0] ESAC_CFG_RESET = 8'h00;
    localparam int ESAC_INDEP_BIT = 7;
    localparam int ESAC_LINE_BIT = 6;
    localparam int ESAC_PHASE_LSB = 0;
    localparam logic [7:0] ESAC_CFG_WMASK = 8'hC3;
    // Sampling grid in half-UI steps, fine and coarse modes
    localparam logic [1:0] ESAC_PH_TARGET = 2'h0;
    localparam logic [1:0] ESAC_PH_EARLY_HALF = 2'h1;
    localparam logic [1:0] ESAC_PH_LATE_ONE = 2'h2;
    localparam logic [1:0] ESAC_PH_LATE_HALF = 2'h3;
    localparam logic [31:0] ESAC_UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic frame_pulse_independence;
        logic line_rate_sync_select;
        logic [1:0] sync_sample_phase;
    } esac_cfg_t;

    typedef struct packed {
        logic align_low_rate;
        logic align_line_rate;
        logic align_frame_pulses;
        logic fine_sampling;
        logic [2:0] sample_delay;
    } esac_ctrl_t;
endpackage

// File: rtl/esac_sampler.sv
// Purpose: Samples the synchronised sync input at a tap set by sample_delay, in half-UI steps
// Assumes: ref_en pulses at twice the selected sampling rate (half-UI steps)
// Notes: Detects the falling edge of sync as the alignment event
`timescale 1ns/1ps
module esac_sampler
    import esac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sampling control
    input wire logic ref_en,
    input wire logic [2:0] sample_delay,
    input wire logic sync_level,
    // Result
    output logic align_pulse
);
    logic [4:0] hist;
    logic prev_sample;
    wire logic sampled = hist[sample_delay];

    // Shift history on each half-UI step; falling edge marks zero offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 5'h1F;
            prev_sample <= 1'b1;
            align_pulse <= 1'b0;
        end else begin
            align_pulse <= 1'b0;
            if (ref_en) begin
                hist <= {hist[3:0], sync_level};
                prev_sample <= sampled;
                align_pulse <= prev_sample & ~sampled; // see (RULE_05)
            end
        end
    end
endmodule // esac_sampler

// File: bench/esac_monitor.sv
// Purpose: Bus and control checks on the sync alignment block
// Assumes: Bound to esac_top, one clock domain
// Notes: Tap choice per phase setting is checked by the bench
`timescale 1ns/1ps
module esac_monitor
    import esac_pkg::*;
(
    // Watched ports, grouped to save space
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic align_low_rate_strobe, align_line_rate_strobe, align_frame_pulse_strobe,
    input wire esac_ctrl_t ctrl
);
    // One domain, so one clocking and one reset guard
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    access_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    unmapped_err_a: assert property (pready && paddr != ESAC_CFG_ADDR |-> pslverr)
        else $error("unmapped access not refused");
    reserved_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 0 && prdata[5:2] == 0)
        else $error("reserved read bits not zero");
    write_mode_a: assert property (psel && penable && pready && pwrite && !pslverr |=> ##1
        ctrl.fine_sampling == $past(pwdata[6], 2) && ctrl.align_frame_pulses != $past(pwdata[7], 2))
        else $error("mode bits not applied");
    line_gate_a: assert property (align_line_rate_strobe |-> ctrl.align_line_rate && align_low_rate_strobe)
        else $error("line strobe while not selected");
    frame_gate_a: assert property (align_frame_pulse_strobe |-> ctrl.align_frame_pulses)
        else $error("frame strobe while independent");
    tap_range_a: assert property (ctrl.align_low_rate |-> ctrl.sample_delay inside {[1:4]})
        else $error("tap out of range");
    strobe_pulse_a: assert property (align_low_rate_strobe |=> !align_low_rate_strobe)
        else $error("strobe longer than one cycle");
endmodule // esac_monitor
bind esac_top esac_monitor i_mon (.*);

// File: bench/esac_sync_src.sv
// Purpose: Far-side sync source with reference grids
// Assumes: Grids arrive as enables on pclk
// Notes: Sync idles high and falls once per go
`timescale 1ns/1ps
module esac_sync_src (
    // Clock and request
    input wire logic pclk,
    input wire logic go,
    // Grids and sync pin
    output logic ref_coarse_en,
    output logic ref_fine_en,
    output logic ext_frame_sync_input
);
    logic [3:0] div = 4'h0;
    int low = 0;
    initial {ref_coarse_en, ref_fine_en, ext_frame_sync_input} = 3'h1;
    // Coarse one in eight, fine one in two; sync falls on the edge after go, at any grid phase
    always @(posedge pclk) begin
        div <= div + 4'h1;
        ref_coarse_en <= div[2:0] == 3'h7;
        ref_fine_en <= div[0];
        low <= go ? 50 : (low > 0 ? low - 1 : 0);
        ext_frame_sync_input <= !(go || low > 1);
    end
endmodule // esac_sync_src

// File: bench/testbench.sv
// Purpose: Self-checking bench for the sync alignment block
// Assumes: Zero-wait APB slave at byte address 0x1EC
// Notes: Register model is q; strobes counted per sync fall
`timescale 1ns/1ps
module testbench;
    import esac_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, q = 32'h0, x = 32'h09403784;
    logic pready, pslverr, err, ref_coarse_en, ref_fine_en, ext_frame_sync_input;
    logic align_low_rate_strobe, align_line_rate_strobe, align_frame_pulse_strobe;
    esac_ctrl_t ctrl;
    int mismatches = 0, n_compared = 0, nl, nn, nf;
    esac_top i_dut (.*);
    esac_sync_src i_src (.*);
    // Clock at 125 MHz
    always #4 pclk = ~pclk;
    // Strobe counts restart at each sync request
    always @(posedge pclk) begin
        nl <= go ? 0 : nl + align_low_rate_strobe;
        nn <= go ? 0 : nn + align_line_rate_strobe;
        nf <= go ? 0 : nf + align_frame_pulse_strobe;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Idle edge first, so no signal is assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk) penable <= 1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        if (k == 20) begin
            mismatches++;
            end_sim;
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, ESAC_CFG_ADDR, 0);
        chk(rd, q);
        for (int i = 0; i < 4; i++) begin
            x = xs(x);
            apb(1, ESAC_CFG_ADDR, (x & 32'hFFFFFF3C) | (i << 6) | (i ^ 1));
            q = ((i << 6) | (i ^ 1)) & 32'hC3;
            apb(0, ESAC_CFG_ADDR, 0);
            chk(rd, q);
            chk(ctrl.sample_delay, (q[1:0] ^ 2'h1) + 3'h1);
            @(posedge pclk) go <= 1;
            @(posedge pclk) go <= 0;
            repeat (100) @(posedge pclk);
            chk(nl, 1);
            chk(nn, q[6]);
            chk(nf, !q[7]);
            $display("mode %0d done", i);
        end
        apb(1, 12'h1F0, 32'hFF);
        chk(err, 1);
        apb(0, ESAC_CFG_ADDR, 0);
        chk(rd, q);
        $display("unmapped done");
        end_sim;
    end
endmodule // testbench
